// File: shared/swc_defines.svh
// Purpose: shared constants of the serial wiper control link
// Assumes: 10 MHz system clock on both ends
// Notes: frame = 4 ignored bits, 4-bit command, 2-bit channel, 6-bit data
`ifndef SWC_DEFINES_SVH
`define SWC_DEFINES_SVH
`define SWC_FRAME_BITS 16
`define SWC_HOST_FRAME_BITS 32
`define SWC_HOST_CNT_W 6
`define SWC_CNT_W 8
`define SWC_CNT_MAX 8'hff
`define SWC_FRAME_LSBS 4
`define SWC_CMD_HI 11
`define SWC_CMD_LO 8
`define SWC_CH_HI 7
`define SWC_CH_LO 6
`define SWC_DATA_HI 5
`define SWC_DATA_LO 0
`define SWC_WIPER_W 6
`define SWC_NCH 4
`define SWC_CH_W 2
`define SWC_MIDSCALE 6'h20
`define SWC_WIPER_MAX 6'h3f
`define SWC_WIPER_MIN 6'h00
`define SWC_CLK_NS 100
`define SWC_NV_WRITE_NS 3000
`define SWC_NV_WRITE_CYC ((`SWC_NV_WRITE_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS)
`define SWC_NV_CNT_W 6
`define SWC_SCLK_NS 800
`define SWC_HALF_CYC ((`SWC_SCLK_NS + 2 * `SWC_CLK_NS - 1) / (2 * `SWC_CLK_NS))
`define SWC_HALF_W 4
`endif

// File: shared/swc_pkg.sv
// Purpose: types of the serial wiper control link
// Assumes: constants come from swc_defines.svh
// Notes: command codes sit in frame bits 11:8
package swc_pkg;
	typedef enum logic [3:0] {
		SWC_NOP = 4'h0, // dummy write, selects channel only
		SWC_WR_IN = 4'h1, // stage data in input register
		SWC_LOAD_CH = 4'h2, // input register to wiper, one channel
		SWC_LOAD_ALL = 4'h3, // input registers to wipers, all channels
		SWC_READ = 4'h4, // read back selected wiper
		SWC_INC_ALL = 4'h5, // step all wipers up
		SWC_DEC_ALL = 4'h6, // step all wipers down
		SWC_STORE_NV = 4'h7, // wiper to nonvolatile store
		SWC_WR_NV = 4'h8, // data to nonvolatile store
		SWC_RESTORE_ALL = 4'h9, // all wipers from nonvolatile store
		SWC_RESTORE_CH = 4'ha // one wiper from nonvolatile store
	} swc_cmd_t;
	// one bit changes per step on idle, shift, exec, readback, idle; store wait is the detour
	typedef enum logic [2:0] {
		SWC_BOOT = 3'b110,
		SWC_IDLE = 3'b000,
		SWC_SHIFT = 3'b001,
		SWC_EXEC = 3'b011,
		SWC_NVWAIT = 3'b111,
		SWC_RBK = 3'b010
	} swc_dstate_t;
	// host states form a closed six-step gray ring
	typedef enum logic [2:0] {
		SWC_H_IDLE = 3'b000,
		SWC_H_LEAD = 3'b001,
		SWC_H_SHIFT = 3'b011,
		SWC_H_TAIL = 3'b111,
		SWC_H_GAP = 3'b110,
		SWC_H_WAIT = 3'b100
	} swc_hstate_t;
endpackage : swc_pkg

// File: shared/swc_link_if.sv
// Purpose: pins between host and wiper control device
// Assumes: all pins are plain one-way wires
// Notes: chainOut of one device feeds serialIn of the next in a chain
`timescale 1ns/10ps
interface swc_link_if;
	logic sclk; // serial clock, host driven, idles low
	logic frameSelN; // frame select, active low
	logic serialIn; // host to device data, msb first
	logic chainSerialOut; // device to host / next device
	logic loadWiperPinN; // active low load strobe
	logic writeProtectN; // active low write protect
	logic nvRestoreOverrideN; // active low preset from store
	logic ready; // device idle, high level
	modport dev (input sclk, frameSelN, serialIn, loadWiperPinN, writeProtectN, nvRestoreOverrideN,
		output chainSerialOut, ready);
	modport host (output sclk, frameSelN, serialIn, loadWiperPinN, writeProtectN, nvRestoreOverrideN,
		input chainSerialOut, ready);
endinterface : swc_link_if

// File: rtl/swc_dev_end.sv
// Purpose: device end of the serial wiper control link
// Assumes: sclk idles low, data sampled on its rising edge, changed on its falling edge
// Notes: all link pins pass two flip-flops; frames of 16 to 240 bits in multiples of 16 keep the last 16
// Operation
// - six-bit data taken from low six bits
// - sixteen-bit transfer, top four bits ignored
// - serial output feeds next device input
// - host shifts 32 bits for two devices
// - frame-select rise commits shifted data
// - wrong clock count discards the frame
// - clock counter cleared while frame-select high
// - increment/decrement steps all wipers together
// - restore command reloads all wipers from store
// - load pin copies input to wiper
// - load one channel or all channels
// - readback returns last selected channel
// - host dummy-writes to select another channel
// - write protect blocks wiper-changing commands
// - restore from store works under protect
// - preset pin overwrites wipers from store
// - ready output shows command finished
// - power cycle reloads wipers, never store
// - without store, reset presets midscale
// - with store, power-up loads stored value
`timescale 1ns/10ps
`include "swc_defines.svh"
module swc_dev_end #(
	parameter bit HAS_NV = 1'b1 // 0 models a part with no store
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic nvFactoryLoad, // writes midscale to every store cell
	output logic [`SWC_WIPER_W*`SWC_NCH-1:0] wiperOut, // all wiper codes, channel 0 lowest
	swc_link_if.dev link
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: stage 1 is read only by stage 2
	logic [2:0] sclkSy; // stages 1..3, 3 only for edge finding
	logic [2:0] csSy;
	logic [2:0] loadSy;
	logic [1:0] sdSy;
	logic [1:0] wpSy;
	logic [1:0] preSy;

	// sync chains, reset to idle pin levels
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclkSy <= '0;
			csSy <= '1;
			loadSy <= '1;
			sdSy <= '0;
			wpSy <= '1;
			preSy <= '1;
		end else begin
			sclkSy <= {sclkSy[1:0], link.sclk};
			csSy <= {csSy[1:0], link.frameSelN};
			loadSy <= {loadSy[1:0], link.loadWiperPinN};
			sdSy <= {sdSy[0], link.serialIn};
			wpSy <= {wpSy[0], link.writeProtectN};
			preSy <= {preSy[0], link.nvRestoreOverrideN};
		end
	end

	logic sclkRise; // rising link clock seen
	logic sclkFall;
	logic csLow; // frame open
	logic csRise; // frame closed
	logic loadFall; // load strobe asserted
	logic protect; // write protect active
	logic presetOn; // preset pin held active
	assign sclkRise = sclkSy[1] & ~sclkSy[2];
	assign sclkFall = ~sclkSy[1] & sclkSy[2];
	assign csLow = ~csSy[1];
	assign csRise = csSy[1] & ~csSy[2];
	assign loadFall = ~loadSy[1] & loadSy[2];
	assign protect = ~wpSy[1];
	assign presetOn = ~preSy[1];

	////////////////////////////////////////////////////////////////////////////
	// nonvolatile store: no reset, so a power cycle never touches it
	logic [`SWC_WIPER_W-1:0] nv_r [`SWC_NCH];
	logic [`SWC_WIPER_W-1:0] nv_nxt [`SWC_NCH];

	// control state
	swc_pkg::swc_dstate_t state_r, state_nxt;
	logic [`SWC_FRAME_BITS-1:0] shift_r, shift_nxt; // in and out share one register
	logic [`SWC_CNT_W-1:0] bitCnt_r, bitCnt_nxt; // link clocks in this frame
	logic outBit_r, outBit_nxt; // serial output flop
	logic [`SWC_CH_W-1:0] selCh_r, selCh_nxt; // channel for readback
	logic [`SWC_NV_CNT_W-1:0] nvCnt_r, nvCnt_nxt; // store write busy time
	logic [`SWC_WIPER_W-1:0] wiper_r [`SWC_NCH];
	logic [`SWC_WIPER_W-1:0] wiper_nxt [`SWC_NCH];
	logic [`SWC_WIPER_W-1:0] inReg_r [`SWC_NCH]; // staged values, do not move wiper
	logic [`SWC_WIPER_W-1:0] inReg_nxt [`SWC_NCH];

	// fields of the committed frame
	swc_pkg::swc_cmd_t cmd;
	logic [`SWC_CH_W-1:0] ch;
	logic [`SWC_WIPER_W-1:0] data;
	logic lenOk; // nonzero multiple of 16 clocks
	assign cmd = swc_pkg::swc_cmd_t'(shift_r[`SWC_CMD_HI:`SWC_CMD_LO]);
	assign ch = shift_r[`SWC_CH_HI:`SWC_CH_LO];
	assign data = shift_r[`SWC_DATA_HI:`SWC_DATA_LO];
	// chained frames are longer, so any whole number of words up to 240 bits is accepted
	assign lenOk = (bitCnt_r != '0) && (bitCnt_r[`SWC_FRAME_LSBS-1:0] == '0);

	////////////////////////////////////////////////////////////////////////////
	// next-state logic of the whole block
	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		bitCnt_nxt = bitCnt_r;
		outBit_nxt = outBit_r;
		selCh_nxt = selCh_r;
		nvCnt_nxt = nvCnt_r;
		wiper_nxt = wiper_r;
		inReg_nxt = inReg_r;
		nv_nxt = nv_r;
		// counter held clear whenever the frame is closed
		if (!csLow) begin
			bitCnt_nxt = '0;
		end
		case (state_r)
			swc_pkg::SWC_BOOT: begin
				// power-up copy from store, no host access needed
				if (HAS_NV) begin
					for (int i = 0; i < `SWC_NCH; i++) begin
						wiper_nxt[i] = nv_r[i];
					end
				end
				state_nxt = swc_pkg::SWC_RBK;
			end
			swc_pkg::SWC_IDLE: begin
				if (csLow) begin
					outBit_nxt = shift_r[`SWC_FRAME_BITS-1]; // first bit before first clock
					state_nxt = swc_pkg::SWC_SHIFT;
				end
			end
			swc_pkg::SWC_SHIFT: begin
				if (csRise) begin
					// nothing is acted on before the select rises
					state_nxt = lenOk ? swc_pkg::SWC_EXEC : swc_pkg::SWC_RBK;
				end else if (sclkRise) begin
					shift_nxt = {shift_r[`SWC_FRAME_BITS-2:0], sdSy[1]};
					if (bitCnt_r != `SWC_CNT_MAX) begin
						bitCnt_nxt = bitCnt_r + 1'b1; // saturates, so runaway frames still fail
					end
				end else if (sclkFall) begin
					outBit_nxt = shift_r[`SWC_FRAME_BITS-1];
				end
			end
			swc_pkg::SWC_EXEC: begin
				state_nxt = swc_pkg::SWC_RBK;
				case (cmd)
					swc_pkg::SWC_NOP: begin
						selCh_nxt = ch;
					end
					swc_pkg::SWC_WR_IN: begin
						selCh_nxt = ch;
						inReg_nxt[ch] = data;
					end
					swc_pkg::SWC_LOAD_CH: begin
						selCh_nxt = ch;
						if (!protect) begin
							wiper_nxt[ch] = inReg_r[ch];
						end
					end
					swc_pkg::SWC_LOAD_ALL: begin
						if (!protect) begin
							wiper_nxt = inReg_r;
						end
					end
					swc_pkg::SWC_INC_ALL: begin
						// every channel moves in the same cycle, clamped at full scale
						for (int i = 0; i < `SWC_NCH; i++) begin
							if (!protect && wiper_r[i] != `SWC_WIPER_MAX) begin
								wiper_nxt[i] = wiper_r[i] + 1'b1;
							end
						end
					end
					swc_pkg::SWC_DEC_ALL: begin
						for (int i = 0; i < `SWC_NCH; i++) begin
							if (!protect && wiper_r[i] != `SWC_WIPER_MIN) begin
								wiper_nxt[i] = wiper_r[i] - 1'b1;
							end
						end
					end
					swc_pkg::SWC_STORE_NV: begin
						selCh_nxt = ch;
						// protect guards the stored contents too
						if (!protect && HAS_NV) begin
							nv_nxt[ch] = wiper_r[ch];
							nvCnt_nxt = '0;
							state_nxt = swc_pkg::SWC_NVWAIT;
						end
					end
					swc_pkg::SWC_WR_NV: begin
						selCh_nxt = ch;
						if (!protect && HAS_NV) begin
							nv_nxt[ch] = data;
							nvCnt_nxt = '0;
							state_nxt = swc_pkg::SWC_NVWAIT;
						end
					end
					swc_pkg::SWC_RESTORE_ALL: begin
						if (HAS_NV) begin
							wiper_nxt = nv_r;
						end
					end
					swc_pkg::SWC_RESTORE_CH: begin
						selCh_nxt = ch;
						if (HAS_NV) begin
							wiper_nxt[ch] = nv_r[ch];
						end
					end
					default: begin
						// read and unknown codes change nothing
					end
				endcase
			end
			swc_pkg::SWC_NVWAIT: begin
				// store write time, ready stays low meanwhile
				if (nvCnt_r == `SWC_NV_CNT_W'(`SWC_NV_WRITE_CYC - 1)) begin
					state_nxt = swc_pkg::SWC_RBK;
				end else begin
					nvCnt_nxt = nvCnt_r + 1'b1;
				end
			end
			swc_pkg::SWC_RBK: begin
				// next frame shifts out the selected wiper
				shift_nxt = '0;
				shift_nxt[`SWC_CH_HI:`SWC_CH_LO] = selCh_r;
				shift_nxt[`SWC_DATA_HI:`SWC_DATA_LO] = wiper_r[selCh_r];
				state_nxt = swc_pkg::SWC_IDLE;
			end
			default: begin
				state_nxt = swc_pkg::SWC_IDLE;
			end
		endcase
		// load strobe copies every staged value; protect blocks it too
		if (loadFall && !protect) begin
			wiper_nxt = inReg_r;
		end
		// preset has the last word over every other wiper change
		if (presetOn && HAS_NV) begin
			wiper_nxt = nv_r;
		end
		// factory programming of the store
		if (nvFactoryLoad) begin
			for (int i = 0; i < `SWC_NCH; i++) begin
				nv_nxt[i] = `SWC_MIDSCALE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= swc_pkg::SWC_BOOT;
			shift_r <= '0;
			bitCnt_r <= '0;
			outBit_r <= 1'b0;
			selCh_r <= '0;
			nvCnt_r <= '0;
			for (int i = 0; i < `SWC_NCH; i++) begin
				wiper_r[i] <= `SWC_MIDSCALE;
				inReg_r[i] <= `SWC_MIDSCALE;
			end
		end else begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			bitCnt_r <= bitCnt_nxt;
			outBit_r <= outBit_nxt;
			selCh_r <= selCh_nxt;
			nvCnt_r <= nvCnt_nxt;
			wiper_r <= wiper_nxt;
			inReg_r <= inReg_nxt;
		end
	end

	// store cells keep their charge through reset
	always_ff @(posedge clk) begin
		nv_r <= nv_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign link.chainSerialOut = outBit_r;
	// ready only in idle; a frame that opens during busy is shifted from idle on, its earlier clocks lost
	assign link.ready = (state_r == swc_pkg::SWC_IDLE);
	for (genvar g = 0; g < `SWC_NCH; g++) begin : gWiper
		assign wiperOut[g*`SWC_WIPER_W +: `SWC_WIPER_W] = wiper_r[g];
	end
endmodule : swc_dev_end

// File: rtl/swc_host_end.sv
// Purpose: host end, shifts one 32-bit frame per request
// Assumes: sclk derived here by a divider; device ready watched through two flops
// Notes: first 16 bits sent end in the farther device of a two-device chain
`timescale 1ns/10ps
`include "swc_defines.svh"
module swc_host_end (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start, // one-cycle request, taken when busy is low
	input wire logic [`SWC_HOST_FRAME_BITS-1:0] txFrame,
	input wire logic loadReq, // level, drives the load strobe
	input wire logic protectReq, // level, drives write protect
	input wire logic presetReq, // level, drives the preset pin
	output logic busy,
	output logic done, // one-cycle pulse, rxFrame valid
	output logic [`SWC_HOST_FRAME_BITS-1:0] rxFrame,
	swc_link_if.host link
);
	////////////////////////////////////////////////////////////////////////////
	// device return pins through two flops
	logic [1:0] misoSy;
	logic [1:0] rdySy;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			misoSy <= '0;
			rdySy <= '0;
		end else begin
			misoSy <= {misoSy[0], link.chainSerialOut};
			rdySy <= {rdySy[0], link.ready};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	swc_pkg::swc_hstate_t state_r, state_nxt;
	logic [`SWC_HALF_W-1:0] half_r, half_nxt; // divider for the half period
	logic [`SWC_HOST_CNT_W-1:0] cnt_r, cnt_nxt; // bits sent
	logic [`SWC_HOST_FRAME_BITS-1:0] tx_r, tx_nxt;
	logic [`SWC_HOST_FRAME_BITS-1:0] rx_r, rx_nxt;
	logic sclk_r, sclk_nxt;
	logic cs_r, cs_nxt;
	logic done_r, done_nxt;
	logic [2:0] pins_r, pins_nxt; // load, protect, preset, active low
	logic tick; // half period elapsed
	// longer chains may need a slower clock: raise the half period
	assign tick = (half_r == `SWC_HALF_W'(`SWC_HALF_CYC - 1));

	// next values of the shifter
	always_comb begin
		state_nxt = state_r;
		half_nxt = tick ? '0 : half_r + 1'b1;
		cnt_nxt = cnt_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		sclk_nxt = sclk_r;
		cs_nxt = cs_r;
		done_nxt = 1'b0;
		pins_nxt = {~loadReq, ~protectReq, ~presetReq};
		case (state_r)
			swc_pkg::SWC_H_IDLE: begin
				half_nxt = '0;
				if (start) begin
					tx_nxt = txFrame;
					cnt_nxt = '0;
					cs_nxt = 1'b0;
					state_nxt = swc_pkg::SWC_H_LEAD;
				end
			end
			swc_pkg::SWC_H_LEAD: begin
				if (tick) begin
					state_nxt = swc_pkg::SWC_H_SHIFT;
				end
			end
			swc_pkg::SWC_H_SHIFT: begin
				if (tick && !sclk_r) begin
					sclk_nxt = 1'b1;
				end else if (tick) begin
					// sample late in the high phase to absorb both sync delays
					sclk_nxt = 1'b0;
					rx_nxt = {rx_r[`SWC_HOST_FRAME_BITS-2:0], misoSy[1]};
					tx_nxt = {tx_r[`SWC_HOST_FRAME_BITS-2:0], 1'b0};
					cnt_nxt = cnt_r + 1'b1;
					// select stays low for all 32 bits
					if (cnt_r == `SWC_HOST_CNT_W'(`SWC_HOST_FRAME_BITS - 1)) begin
						state_nxt = swc_pkg::SWC_H_TAIL;
					end
				end
			end
			swc_pkg::SWC_H_TAIL: begin
				if (tick) begin
					cs_nxt = 1'b1;
					state_nxt = swc_pkg::SWC_H_GAP;
				end
			end
			swc_pkg::SWC_H_GAP: begin
				// give the device time to drop ready
				if (tick) begin
					state_nxt = swc_pkg::SWC_H_WAIT;
				end
			end
			swc_pkg::SWC_H_WAIT: begin
				if (rdySy[1]) begin
					done_nxt = 1'b1;
					state_nxt = swc_pkg::SWC_H_IDLE;
				end
			end
			default: begin
				state_nxt = swc_pkg::SWC_H_IDLE;
			end
		endcase
	end

	// registers of the shifter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= swc_pkg::SWC_H_IDLE;
			half_r <= '0;
			cnt_r <= '0;
			tx_r <= '0;
			rx_r <= '0;
			sclk_r <= 1'b0;
			cs_r <= 1'b1;
			done_r <= 1'b0;
			pins_r <= '1;
		end else begin
			state_r <= state_nxt;
			half_r <= half_nxt;
			cnt_r <= cnt_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			sclk_r <= sclk_nxt;
			cs_r <= cs_nxt;
			done_r <= done_nxt;
			pins_r <= pins_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign link.sclk = sclk_r;
	assign link.frameSelN = cs_r;
	assign link.serialIn = tx_r[`SWC_HOST_FRAME_BITS-1];
	assign link.loadWiperPinN = pins_r[2];
	assign link.writeProtectN = pins_r[1];
	assign link.nvRestoreOverrideN = pins_r[0];
	assign busy = (state_r != swc_pkg::SWC_H_IDLE);
	assign done = done_r;
	assign rxFrame = rx_r;
endmodule : swc_host_end

// File: verif/swc_link_checker.sv
// Purpose: timing checks on the host-to-device link pins
// Assumes: one clk domain, rst_n async active low
// Notes: host frames are always 32 bits long
`timescale 1ns/10ps
module swc_link_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic frameSelN,
	input wire logic serialIn,
	input wire logic ready
);
	logic sclkPrev_r, sclkPrev_nxt; // sclk one clk ago
	logic [5:0] riseCnt_r, riseCnt_nxt; // sclk rises in the open frame
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////
	// count link clock rises, cleared while select is high
	always_comb begin
		sclkPrev_nxt = sclk;
		riseCnt_nxt = riseCnt_r;
		if (frameSelN) begin
			riseCnt_nxt = 6'h00; // idle: nothing counted
		end else if (sclk && !sclkPrev_r) begin
			riseCnt_nxt = riseCnt_r + 6'h01; // 6 bits: 32 fits with room
		end
	end
	// registers only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclkPrev_r <= 1'b0;
			riseCnt_r <= 6'h00;
		end else begin
			sclkPrev_r <= sclkPrev_nxt;
			riseCnt_r <= riseCnt_nxt;
		end
	end
	////////////////////////////////////////////////////////////
	AST_IDLE_LOW: assert property (frameSelN |-> !sclk)
		else $error("link clock high outside a frame");
	AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("link clock high phase not four clocks");
	AST_DATA_STABLE: assert property (sclk && $past(sclk) |-> $stable(serialIn))
		else $error("serial data moved while link clock high");
	AST_LEAD: assert property ($fell(frameSelN) |-> !sclk [*7])
		else $error("link clock rose too soon after select");
	AST_COUNT32: assert property ($rose(frameSelN) |-> riseCnt_r == 6'h20)
		else $error("host frame not 32 clocks");
	AST_GAP: assert property ($rose(frameSelN) |-> frameSelN [*4])
		else $error("select high time too short");
	AST_BUSY: assert property (!frameSelN [*5] |-> !ready)
		else $error("ready high inside a frame");
	AST_READY_BACK: assert property ($rose(frameSelN) |-> ##[1:50] ready)
		else $error("ready did not return after commit");
	AST_START_READY: assert property ($fell(frameSelN) |-> $past(ready))
		else $error("frame opened while device not ready");
endmodule : swc_link_checker

// File: verif/serial_wiper_control_tb.sv
// Purpose: host and device ends joined, plus a bit-banged second device
// Assumes: 10 MHz clk, link clock 800 ns
// Notes: second device has no store and sees bad frame lengths
`timescale 1ns/10ps
`include "swc_defines.svh"
module serial_wiper_control_tb;
	logic clk = 1'b0; // 100 ns period
	logic rst_n = 1'b0; // async, active low
	logic start = 1'b0; // host request pulse
	logic [31:0] txFrame = 32'h00000000; // host frame out
	logic loadReq = 1'b0, protectReq = 1'b0, presetReq = 1'b0; // pin levels
	logic nvFactoryLoad = 1'b1; // fills store while reset holds
	logic busy, done; // host status
	logic [31:0] rxFrame; // host frame in
	logic [23:0] wiperA, wiperB; // wiper codes of both devices
	logic [5:0] expW [4]; // expected wipers, device A
	logic [5:0] expNv [4]; // expected store, device A
	int errTotal = 0;
	int numChecks = 0;
	swc_link_if linkA();
	swc_link_if linkB();
	swc_host_end swc_host_end_inst (.clk(clk), .rst_n(rst_n), .start(start), .txFrame(txFrame),
		.loadReq(loadReq), .protectReq(protectReq), .presetReq(presetReq), .busy(busy), .done(done),
		.rxFrame(rxFrame), .link(linkA.host));
	swc_dev_end swc_dev_end_inst (.clk(clk), .rst_n(rst_n), .nvFactoryLoad(nvFactoryLoad),
		.wiperOut(wiperA), .link(linkA.dev));
	// storeless variant on a bench-driven link
	swc_dev_end #(.HAS_NV(1'b0)) swc_dev_end_inst_b (.clk(clk), .rst_n(rst_n),
		.nvFactoryLoad(nvFactoryLoad), .wiperOut(wiperB), .link(linkB.dev));
	swc_link_checker swc_link_checker_inst (.clk(clk), .rst_n(rst_n), .sclk(linkA.sclk),
		.frameSelN(linkA.frameSelN), .serialIn(linkA.serialIn), .ready(linkA.ready));
	always #50 clk = ~clk;
	////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrapUp
	// one comparison
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errTotal++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// a hang counts as a mismatch
	task automatic hang();
		errTotal++;
		$display("mismatch at %0t: wait ran out", $time);
		wrapUp();
	endtask : hang
	function automatic logic [31:0] packW();
		return {8'h00, expW[3], expW[2], expW[1], expW[0]};
	endfunction : packW
	////////////////////////////////////////////////////////////
	// one 32-bit host frame; upper half is junk that must only pass through
	task automatic xfer(input swc_pkg::swc_cmd_t cmd, input logic [1:0] ch, input logic [5:0] d);
		int i;
		logic [15:0] low;
		low = {4'hf, cmd, ch, d};
		@(posedge clk);
		start <= 1'b1;
		txFrame <= {~low, low};
		@(posedge clk);
		start <= 1'b0;
		for (i = 0; i < 1000 && done !== 1'b1; i++) @(posedge clk);
		if (done !== 1'b1) hang();
		check({16'h0000, rxFrame[15:0]}, {16'h0000, ~low});
		// host is back in idle in the cycle that shows done
		check({31'h00000000, busy}, 32'h00000000);
	endtask : xfer
	// step all wipers with clamping
	task automatic stepAll(input logic up);
		xfer(up ? swc_pkg::SWC_INC_ALL : swc_pkg::SWC_DEC_ALL, 2'd0, 6'h00);
		foreach (expW[i]) begin
			if (up && expW[i] != 6'h3f) expW[i]++;
			else if (!up && expW[i] != 6'h00) expW[i]--;
		end
	endtask : stepAll
	// wiggle pin level through the host, then let it settle
	task automatic pulseLoad();
		loadReq <= 1'b1;
		tick(8);
		loadReq <= 1'b0;
		tick(8);
	endtask : pulseLoad
	// bit-banged frame of n clocks on the second link, msb first
	task automatic bang(input int n, input logic [15:0] w);
		int i;
		@(posedge clk) linkB.frameSelN <= 1'b0;
		tick(8);
		for (i = n - 1; i >= 0; i--) begin
			linkB.serialIn <= (i < 16) ? w[i] : 1'b1;
			tick(4);
			linkB.sclk <= 1'b1;
			tick(4);
			linkB.sclk <= 1'b0;
		end
		tick(4);
		linkB.frameSelN <= 1'b1;
		linkB.serialIn <= ~linkB.serialIn; // released line shows no stale bit
		tick(6);
		for (i = 0; i < 100 && linkB.ready !== 1'b1; i++) @(posedge clk);
		if (linkB.ready !== 1'b1) hang();
	endtask : bang
	////////////////////////////////////////////////////////////
	initial begin
		linkB.sclk = 1'b0;
		linkB.frameSelN = 1'b1;
		linkB.serialIn = 1'b0;
		linkB.loadWiperPinN = 1'b1;
		linkB.writeProtectN = 1'b1;
		linkB.nvRestoreOverrideN = 1'b1;
		foreach (expW[i]) expW[i] = 6'h20;
		foreach (expNv[i]) expNv[i] = 6'h20;
		tick(8);
		rst_n <= 1'b1;
		tick(2);
		nvFactoryLoad <= 1'b0;
		tick(10);
		check(wiperA, packW());
		check(wiperB, packW());
		// staged write does not move wiper until the load pin
		xfer(swc_pkg::SWC_WR_IN, 2'd1, 6'h15);
		check(wiperA, packW());
		pulseLoad();
		expW[1] = 6'h15;
		check(wiperA, packW());
		// load one channel, then all
		xfer(swc_pkg::SWC_WR_IN, 2'd2, 6'h0a);
		xfer(swc_pkg::SWC_LOAD_CH, 2'd2, 6'h00);
		expW[2] = 6'h0a;
		check(wiperA, packW());
		xfer(swc_pkg::SWC_WR_IN, 2'd0, 6'h3f);
		xfer(swc_pkg::SWC_WR_IN, 2'd3, 6'h01);
		xfer(swc_pkg::SWC_LOAD_ALL, 2'd1, 6'h00);
		expW[0] = 6'h3f;
		expW[3] = 6'h01;
		check(wiperA, packW());
		$display("load tests done");
		// step together, clamping at both ends
		stepAll(1'b1);
		check(wiperA, packW());
		stepAll(1'b0);
		stepAll(1'b0);
		stepAll(1'b0);
		check(wiperA, packW());
		$display("step tests done");
		// dummy write selects; read names another channel on purpose
		xfer(swc_pkg::SWC_NOP, 2'd2, 6'h00);
		xfer(swc_pkg::SWC_READ, 2'd1, 6'h00);
		check({16'h0000, rxFrame[31:16]}, {16'h0000, 8'h00, 2'd2, expW[2]});
		xfer(swc_pkg::SWC_NOP, 2'd0, 6'h00);
		xfer(swc_pkg::SWC_READ, 2'd3, 6'h00);
		check({16'h0000, rxFrame[31:16]}, {16'h0000, 8'h00, 2'd0, expW[0]});
		$display("readback tests done");
		// store writes, then restores
		xfer(swc_pkg::SWC_WR_NV, 2'd1, 6'h11);
		xfer(swc_pkg::SWC_WR_NV, 2'd3, 6'h33);
		xfer(swc_pkg::SWC_STORE_NV, 2'd2, 6'h00);
		expNv[1] = 6'h11;
		expNv[3] = 6'h33;
		expNv[2] = expW[2];
		check(wiperA, packW());
		xfer(swc_pkg::SWC_RESTORE_ALL, 2'd0, 6'h00);
		expW = expNv;
		check(wiperA, packW());
		stepAll(1'b1);
		xfer(swc_pkg::SWC_RESTORE_CH, 2'd0, 6'h00);
		expW[0] = expNv[0];
		check(wiperA, packW());
		stepAll(1'b1);
		presetReq <= 1'b1;
		tick(8);
		expW = expNv;
		check(wiperA, packW());
		presetReq <= 1'b0;
		tick(4);
		$display("store tests done");
		// protect blocks changes, restore still acts
		stepAll(1'b1);
		protectReq <= 1'b1;
		tick(6);
		xfer(swc_pkg::SWC_INC_ALL, 2'd0, 6'h00);
		xfer(swc_pkg::SWC_WR_IN, 2'd0, 6'h07);
		xfer(swc_pkg::SWC_LOAD_CH, 2'd0, 6'h00);
		pulseLoad();
		check(wiperA, packW());
		xfer(swc_pkg::SWC_WR_NV, 2'd0, 6'h01);
		xfer(swc_pkg::SWC_RESTORE_ALL, 2'd0, 6'h00);
		expW = expNv;
		check(wiperA, packW());
		protectReq <= 1'b0;
		tick(4);
		$display("protect tests done");
		// power cycle reloads from the untouched store
		stepAll(1'b1);
		rst_n <= 1'b0;
		tick(3);
		rst_n <= 1'b1;
		tick(12);
		expW = expNv;
		check(wiperA, packW());
		$display("reset test done");
		// second link: wrong lengths discarded, counter cleared between frames
		bang(17, {4'h0, swc_pkg::SWC_INC_ALL, 8'h00});
		bang(15, {4'h0, swc_pkg::SWC_INC_ALL, 8'h00});
		check(wiperB, {8'h00, {4{6'h20}}});
		bang(8, 16'h0000);
		bang(16, {4'h0, swc_pkg::SWC_INC_ALL, 8'h00});
		check(wiperB, {8'h00, {4{6'h21}}});
		$display("frame length tests done");
		wrapUp();
	end
endmodule : serial_wiper_control_tb
